/* File: core/cbm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cbm_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_req_i,
  input wire logic [2:0] tx_buf_i,
  output cbm_pkg::cbm_txdesc_type tx_desc_o,
  input wire logic rx_valid_i,
  input wire cbm_pkg::cbm_ident_type rx_frame_i,
  input wire cbm_pkg::cbm_ident_type [1:0] filt_i,
  output logic [1:0] accept_o,
  output logic accept_valid_o,
  output logic [5:0] buffer_is_transmitter_o
);
  import cbm_pkg::*;

  // ===========================================================================
  // state
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  logic [7:0] dir_r;
  logic [7:0] dir_nxt;
  logic [7:0] len_r [NUM_BUF];
  logic [7:0] len_nxt [NUM_BUF];
  cbm_mask_type mask_r [NUM_MASK];
  cbm_mask_type mask_nxt [NUM_MASK];
  logic [5:0] txbuf_r;
  logic [5:0] txbuf_nxt;
  logic acc_v_r;
  logic acc_v_nxt;
  logic [1:0] hit;

  // ===========================================================================
  // decode
  logic req;
  logic wr;
  logic enh;
  logic cfg;
  logic len_hit;
  logic mask_hit;
  logic [2:0] lidx;
  logic midx;
  logic [1:0] mfld;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] lenq;
  logic sel_ok;
  logic [7:0] txbuf_ext;
  logic is_tx_sel;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign enh = (ctrl_r[1:0] != CBM_MODE_LEGACY);
  assign cfg = ctrl_r[CTRL_CFG_BIT];
  assign lidx = wb_adr_i[4:2];
  assign len_hit = (wb_adr_i[7:5] == LEN_PAGE) && (lidx < 3'(NUM_BUF)) && (wb_adr_i[1:0] == 2'h0);
  assign mask_hit = (wb_adr_i[7:5] == MASK_PAGE) && (wb_adr_i[1:0] == 2'h0);
  assign midx = wb_adr_i[4];
  assign mfld = wb_adr_i[3:2];
  assign sel_ok = (tx_buf_i < 3'(NUM_BUF));
  assign lenq = sel_ok ? len_r[tx_buf_i] : 8'h00;
  // buffers 6 and 7 do not exist; padding keeps the index in range and makes them receivers
  assign txbuf_ext = {2'b00, txbuf_r};
  assign is_tx_sel = txbuf_ext[tx_buf_i];

  // ===========================================================================
  // register file
  always_comb begin
    ctrl_nxt = ctrl_r;
    dir_nxt = dir_r;
    len_nxt = len_r;
    mask_nxt = mask_r;
    rbyte = 8'h00;
    if (wb_adr_i == ADDR_CTRL) begin
      rbyte = {5'h00, ctrl_r};
      if (wr) begin
        ctrl_nxt[CTRL_CFG_BIT] = wbyte[CTRL_CFG_BIT];
        // code 3 is no mode; such a write leaves the mode alone
        if (wbyte[1:0] != 2'b11) begin
          ctrl_nxt[1:0] = wbyte[1:0];
        end
      end
    end else if (wb_adr_i == ADDR_STATUS) begin
      rbyte = {4'h0, enh, cfg, hit};
    end else if (wb_adr_i == ADDR_DIR) begin
      rbyte = enh ? dir_r : 8'h00;
      if (wr && enh) begin
        dir_nxt = {wbyte[7:DIR_LSB], 2'b00};
      end
    end else if (len_hit) begin
      rbyte = enh ? len_r[lidx] : 8'h00;
      if (wr && enh) begin
        len_nxt[lidx] = wbyte & LEN_WMASK;
      end
    end else if (mask_hit) begin
      unique case (mfld)
        MF_STD_HIGH: begin
          rbyte = mask_r[midx].short_identifier_bits[10:3];
        end
        MF_STD_LOW: begin
          rbyte = {mask_r[midx].short_identifier_bits[2:0], 1'b0, mask_r[midx].id_type_en && enh, 1'b0,
                   mask_r[midx].long_identifier_bits[17:16]};
        end
        MF_EXT_HIGH: begin
          rbyte = mask_r[midx].long_identifier_bits[15:8];
        end
        MF_EXT_LOW: begin
          rbyte = mask_r[midx].long_identifier_bits[7:0];
        end
      endcase
      // masks only move in configuration mode so a frame never meets half a mask
      if (wr && cfg) begin
        unique case (mfld)
          MF_STD_HIGH: begin
            mask_nxt[midx].short_identifier_bits[10:3] = wbyte;
          end
          MF_STD_LOW: begin
            mask_nxt[midx].short_identifier_bits[2:0] = wbyte[7:5];
            mask_nxt[midx].long_identifier_bits[17:16] = wbyte[1:0];
            if (enh) begin
              mask_nxt[midx].id_type_en = wbyte[MLOW_TYPE_BIT];
            end
          end
          MF_EXT_HIGH: begin
            mask_nxt[midx].long_identifier_bits[15:8] = wbyte;
          end
          MF_EXT_LOW: begin
            mask_nxt[midx].long_identifier_bits[7:0] = wbyte;
          end
        endcase
      end
    end
  end

  // ===========================================================================
  // bus answer and status outputs
  always_comb begin
    ack_nxt = req;
    dat_nxt = (req && !wb_we_i) ? {24'h0, rbyte} : 32'h0;
    // in legacy mode every buffer acts as a receiver
    txbuf_nxt = enh ? dir_nxt[7:DIR_LSB] : 6'h00;
    acc_v_nxt = rx_valid_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      ctrl_r <= CTRL_RESET;
      dir_r <= DIR_RESET;
      txbuf_r <= 6'h00;
      acc_v_r <= 1'b0;
      for (int i = 0; i < NUM_BUF; i++) begin
        len_r[i] <= LEN_RESET;
      end
      for (int i = 0; i < NUM_MASK; i++) begin
        mask_r[i] <= MASK_RESET;
      end
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      dir_r <= dir_nxt;
      txbuf_r <= txbuf_nxt;
      acc_v_r <= acc_v_nxt;
      len_r <= len_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign buffer_is_transmitter_o = txbuf_r;
  assign accept_valid_o = acc_v_r;
  assign accept_o = hit;

  // ===========================================================================
  // transmit descriptor and acceptance
  cbm_tx_desc u_tx (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .req_i(tx_req_i),
    .sel_ok_i(sel_ok),
    .is_tx_i(is_tx_sel),
    .enh_i(enh),
    .len_byte_i(lenq),
    .desc_o(tx_desc_o)
  );

  for (genvar m = 0; m < NUM_MASK; m++) begin : g_mask
    cbm_accept u_acc (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .valid_i(rx_valid_i),
      .enh_i(enh),
      .frame_i(rx_frame_i),
      .filt_i(filt_i[m]),
      .mask_i(mask_r[m]),
      .hit_o(hit[m])
    );
  end

  // ===========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic past_sel_ok;
  logic [28:0] diff0;
  assign diff0 = rx_frame_i.id ^ filt_i[0].id;
  logic [28:0] diff1;
  assign diff1 = rx_frame_i.id ^ filt_i[1].id;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      past_sel_ok <= 1'b0;
    end else begin
      past_sel_ok <= sel_ok;
    end
  end

  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_RTR_FOLLOWS: assert property (tx_req_i ##1 tx_desc_o.valid |->
    tx_desc_o.rtr == $past(lenq[LEN_RTR_BIT]))
    else $error("remote flag differs from buffer bit");
  AST_LEN_DIRECT: assert property (tx_req_i && lenq[3:0] <= LEN_MAX |=>
    tx_desc_o.len == $past(lenq[3:0]) && !tx_desc_o.reserved)
    else $error("length code not passed through");
  AST_LEN_RESERVED: assert property (tx_req_i && lenq[3:0] > LEN_MAX |=>
    tx_desc_o.reserved && tx_desc_o.len == LEN_MAX)
    else $error("reserved length not flagged");
  AST_DIR_WRITE: assert property (wr && enh && wb_adr_i == ADDR_DIR |->
    ##1 buffer_is_transmitter_o == $past(wbyte[7:DIR_LSB]) ##1 wb_ack_o == 1'b0)
    else $error("direction write not applied");
  AST_LEGACY_READ: assert property (req && !wb_we_i && !enh &&
    (wb_adr_i == ADDR_DIR || len_hit) |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("legacy mode shows buffer registers");
  AST_TYPE_MISMATCH: assert property (rx_valid_i && enh && mask_r[0].id_type_en &&
    rx_frame_i.ext != filt_i[0].ext |=> accept_valid_o && !accept_o[0])
    else $error("wrong id type accepted");
  AST_ID_MATCH: assert property (rx_valid_i && rx_frame_i.ext &&
    !(enh && mask_r[0].id_type_en) && ((diff0 & {mask_r[0].short_identifier_bits, mask_r[0].long_identifier_bits}) == 29'h0)
    |=> accept_o[0])
    else $error("matching frame refused");
  AST_TYPE_EN_LEGACY: assert property (req && !wb_we_i && !enh && mask_hit &&
    mfld == MF_STD_LOW |=> wb_dat_o[MLOW_TYPE_BIT] == 1'b0)
    else $error("type enable visible in legacy mode");
  AST_LOW_GAPS: assert property (req && !wb_we_i && mask_hit && mfld == MF_STD_LOW
    |=> wb_dat_o[4] == 1'b0 && wb_dat_o[2] == 1'b0)
    else $error("unused mask bits read nonzero");
  AST_RX_NO_DESC: assert property (tx_desc_o.valid |-> $past(tx_req_i) && past_sel_ok &&
    $past(is_tx_sel))
    else $error("descriptor from receive buffer");

  // ===========================================================================
  // checks: register guards and mask comparison
  AST_MASK_LOCKED: assert property (
    wr && mask_hit && !cfg |=>
    mask_r[0] == $past(mask_r[0]) && mask_r[1] == $past(mask_r[1]))
    else $error("mask written outside configuration mode");

  AST_STD_HIGH_WRITE: assert property (
    wr && cfg && mask_hit && !midx && mfld == MF_STD_HIGH |=>
    mask_r[0].short_identifier_bits[10:3] == $past(wbyte))
    else $error("mask standard high byte not stored");

  AST_STD_LOW_WRITE: assert property (
    wr && cfg && mask_hit && !midx && mfld == MF_STD_LOW |=>
    mask_r[0].short_identifier_bits[2:0] == $past(wbyte[7:5]) && mask_r[0].long_identifier_bits[17:16] == $past(wbyte[1:0]))
    else $error("mask low byte fields not stored");

  AST_EXT_HIGH_WRITE: assert property (
    wr && cfg && mask_hit && !midx && mfld == MF_EXT_HIGH |=>
    mask_r[0].long_identifier_bits[15:8] == $past(wbyte))
    else $error("mask extended high byte not stored");

  AST_EXT_LOW_WRITE: assert property (
    wr && cfg && mask_hit && midx && mfld == MF_EXT_LOW |=>
    mask_r[1].long_identifier_bits[7:0] == $past(wbyte))
    else $error("second mask extended low byte not stored");

  AST_TYPE_EN_KEPT: assert property (
    wr && cfg && !enh && mask_hit && !midx && mfld == MF_STD_LOW |=>
    mask_r[0].id_type_en == $past(mask_r[0].id_type_en))
    else $error("type enable written in legacy mode");

  AST_DIR_LEGACY_WRITE: assert property (
    wr && !enh && wb_adr_i == ADDR_DIR |=>
    dir_r == $past(dir_r))
    else $error("direction written in legacy mode");

  AST_LEN_LEGACY_WRITE: assert property (
    wr && !enh && len_hit && lidx == 3'h0 |=>
    len_r[0] == $past(len_r[0]))
    else $error("length written in legacy mode");

  AST_LEN_WRITE: assert property (
    wr && enh && len_hit && lidx == 3'h0 |=>
    len_r[0] == ($past(wbyte) & LEN_WMASK))
    else $error("length byte not stored");

  AST_LEGACY_NO_TX: assert property (
    !$past(enh) |->
    buffer_is_transmitter_o == 6'h00)
    else $error("transmitter shown in legacy mode");

  AST_DESC_ENH: assert property (
    tx_desc_o.valid |->
    $past(enh))
    else $error("descriptor issued in legacy mode");

  AST_STD_ID_MISS: assert property (
    rx_valid_i && !rx_frame_i.ext && ((diff0[28:18] & mask_r[0].short_identifier_bits) != 11'h0) |=>
    accept_valid_o && !accept_o[0])
    else $error("standard frame accepted despite masked difference");

  AST_EXT_ID_MISS: assert property (
    rx_valid_i && rx_frame_i.ext && ((diff0 & {mask_r[0].short_identifier_bits, mask_r[0].long_identifier_bits}) != 29'h0) |=>
    accept_valid_o && !accept_o[0])
    else $error("extended frame accepted despite masked difference");

  AST_STD_ANY_TYPE: assert property (
    rx_valid_i && !rx_frame_i.ext && !(enh && mask_r[1].id_type_en) &&
    ((diff1[28:18] & mask_r[1].short_identifier_bits) == 11'h0) |=> accept_o[1])
    else $error("matching standard frame refused by second mask");

  COV_TX_SEND: cover property (tx_req_i ##1 tx_desc_o.valid && tx_desc_o.rtr);
  COV_ACCEPT: cover property (rx_valid_i ##1 accept_o == 2'b11);
  COV_MASK_WRITE: cover property (wr && mask_hit && cfg ##1 wb_ack_o);
  COV_LEN_RESERVED: cover property (tx_req_i ##1 tx_desc_o.reserved);
  COV_LEGACY_FRAME: cover property (rx_valid_i && !enh ##1 accept_o == 2'b11);

endmodule : cbm_top
`default_nettype wire

/* File: core/cbm_pkg.sv */
// What this block does
// - transmit remote-request bit 6 sets the sent frame's remote flag when 1, clears when 0.
// - length bits 3-0 give 0 to 8 bytes directly; codes 1001 to 1111 are reserved.
// - direction bits 7-2 make buffers 5-0 transmitters when 1; reset 0, all receivers.
// - length and direction registers exist only in enhanced modes 1 and 2, not mode 0.
// - id-type enable 1 accepts only frames whose id type matches the filter's type bit.
// - id-type enable 0 accepts standard and extended frames that pass the id comparison.
// - id-type enable bit exists only in modes 1 and 2, reads zero in mode 0, resets 0.
// - mask low byte holds short id bits 2-0 at 7-5, long bits 17-16 at 1-0.
// - mask extended-high byte holds long id mask bits 15 to 8, all writable.
// - two masks, 0 and 1, each with standard-low, extended-high and extended-low bytes.
// - length layout applies to a buffer only while its direction bit selects transmit.
package cbm_pkg;

  // ===========================================================================
  // sizes and register map
  localparam int unsigned NUM_BUF = 6;
  localparam int unsigned NUM_MASK = 2;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DIR = 8'h08;
  localparam logic [2:0] LEN_PAGE = 3'h1;
  localparam logic [2:0] MASK_PAGE = 3'h2;
  localparam logic [1:0] MF_STD_HIGH = 2'h0;
  localparam logic [1:0] MF_STD_LOW = 2'h1;
  localparam logic [1:0] MF_EXT_HIGH = 2'h2;
  localparam logic [1:0] MF_EXT_LOW = 2'h3;

  // ===========================================================================
  // field positions and values
  localparam int unsigned CTRL_CFG_BIT = 2;
  localparam int unsigned LEN_RTR_BIT = 6;
  localparam int unsigned MLOW_TYPE_BIT = 3;
  localparam int unsigned DIR_LSB = 2;
  localparam logic [7:0] LEN_WMASK = 8'h4f;
  localparam logic [3:0] LEN_MAX = 4'h8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LEN_RESET = 8'h00;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  typedef enum logic [1:0] {
    CBM_MODE_LEGACY = 2'b00,
    CBM_MODE_ENH = 2'b01,
    CBM_MODE_FIFO = 2'b10
  } cbm_mode_type;

  typedef struct packed {
    logic [10:0] short_identifier_bits;
    logic [17:0] long_identifier_bits;
    logic id_type_en;
  } cbm_mask_type;

  typedef struct packed {
    logic [28:0] id;
    logic ext;
  } cbm_ident_type;

  typedef struct packed {
    logic valid;
    logic rtr;
    logic [3:0] len;
    logic reserved;
  } cbm_txdesc_type;

  localparam cbm_mask_type MASK_RESET = '0;

endpackage : cbm_pkg

/* File: core/cbm_accept.sv */
`timescale 1ns/1ps
`default_nettype none
module cbm_accept (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic valid_i,
  input wire logic enh_i,
  input wire cbm_pkg::cbm_ident_type frame_i,
  input wire cbm_pkg::cbm_ident_type filt_i,
  input wire cbm_pkg::cbm_mask_type mask_i,
  output logic hit_o
);
  import cbm_pkg::*;

  // ===========================================================================
  // comparison
  logic hit_r;
  logic hit_nxt;
  logic [28:0] diff;
  logic id_ok;
  logic type_ok;

  always_comb begin
    diff = frame_i.id ^ filt_i.id;
    // standard frames sit in the top eleven id bits; the long bits are not compared
    if (frame_i.ext) begin
      id_ok = ((diff & {mask_i.short_identifier_bits, mask_i.long_identifier_bits}) == 29'h0);
    end else begin
      id_ok = ((diff[28:18] & mask_i.short_identifier_bits) == 11'h0);
    end
    // enable acts only in enhanced modes, so legacy mode accepts both types
    type_ok = !(enh_i && mask_i.id_type_en) || (frame_i.ext == filt_i.ext);
    hit_nxt = valid_i ? (id_ok && type_ok) : hit_r;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;

endmodule : cbm_accept
`default_nettype wire

/* File: core/cbm_tx_desc.sv */
`timescale 1ns/1ps
`default_nettype none
module cbm_tx_desc (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic sel_ok_i,
  input wire logic is_tx_i,
  input wire logic enh_i,
  input wire logic [7:0] len_byte_i,
  output cbm_pkg::cbm_txdesc_type desc_o
);
  import cbm_pkg::*;

  // ===========================================================================
  // descriptor
  cbm_txdesc_type desc_r;
  cbm_txdesc_type desc_nxt;

  always_comb begin
    desc_nxt = desc_r;
    desc_nxt.valid = req_i && sel_ok_i && is_tx_i && enh_i;
    if (req_i) begin
      desc_nxt.rtr = len_byte_i[LEN_RTR_BIT];
      desc_nxt.reserved = (len_byte_i[3:0] > LEN_MAX);
      // reserved codes go out as eight bytes, the most a frame can carry
      desc_nxt.len = desc_nxt.reserved ? LEN_MAX : len_byte_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      desc_r <= '0;
    end else begin
      desc_r <= desc_nxt;
    end
  end

  assign desc_o = desc_r;

endmodule : cbm_tx_desc
`default_nettype wire

/* File: test/cbm_can_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cbm_can_model (
  input wire logic clk_i,
  output logic tx_req_o,
  output logic [2:0] tx_buf_o,
  output logic rx_valid_o,
  output cbm_pkg::cbm_ident_type rx_frame_o,
  output cbm_pkg::cbm_ident_type [1:0] filt_o
);
  import cbm_pkg::*;
  // ==========================================================================
  // protocol engine side: one-cycle frames and transmit requests
  initial begin
    tx_req_o = 1'b0;
    tx_buf_o = 3'h0;
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
    filt_o = '0;
  end
  task automatic send(input cbm_ident_type f, input cbm_ident_type t);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_frame_o <= f;
    filt_o <= {t, t};
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    // stale frame would hide a late sample, so show its inverse
    rx_frame_o <= ~f;
  endtask : send
  task automatic req(input logic [2:0] k);
    @(posedge clk_i);
    tx_req_o <= 1'b1;
    tx_buf_o <= k;
    @(posedge clk_i);
    tx_req_o <= 1'b0;
    tx_buf_o <= ~k;
  endtask : req
endmodule : cbm_can_model
`default_nettype wire

/* File: test/tb_cbm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cbm_top;
  import cbm_pkg::*;
  logic clk, resetn, cyc, stb, we, ack, tx_req, rx_valid, acc_v;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rdv;
  logic [2:0] tx_buf;
  logic [1:0] accept;
  logic [5:0] is_tx;
  cbm_txdesc_type desc;
  cbm_ident_type frame;
  cbm_ident_type [1:0] filt;
  int mismatches, comparisons, cycles;
  localparam cbm_ident_type FS = {11'h5a5, 18'h0, 1'b0};
  localparam cbm_ident_type FE = {11'h5a5, 18'h0, 1'b1};
  localparam cbm_ident_type FD = {11'h5a4, 18'h0, 1'b0};
  localparam cbm_ident_type FX = {11'h5a5, 18'h00100, 1'b1};
  localparam cbm_ident_type FY = {11'h5a5, 18'h00100, 1'b0};
  localparam logic [7:0] ROW_ADR [6] = '{8'h08, 8'h20, 8'h44, 8'h48, 8'h5c, 8'hfc};
  localparam logic [7:0] ROW_WR [6] = '{8'hff, 8'hff, 8'hff, 8'ha5, 8'h3c, 8'hff};
  localparam logic [7:0] ROW_RD [6] = '{8'hfc, 8'h4f, 8'heb, 8'ha5, 8'h3c, 8'h00};

  cbm_top cbm_top_i (.clk_i(clk), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tx_req_i(tx_req), .tx_buf_i(tx_buf), .tx_desc_o(desc),
    .rx_valid_i(rx_valid), .rx_frame_i(frame), .filt_i(filt), .accept_o(accept),
    .accept_valid_o(acc_v), .buffer_is_transmitter_o(is_tx));
  cbm_can_model cbm_can_model_i (.clk_i(clk), .tx_req_o(tx_req), .tx_buf_o(tx_buf),
    .rx_valid_o(rx_valid), .rx_frame_o(frame), .filt_o(filt));

  // ==========================================================================
  // clock, timeout and verdict
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // ==========================================================================
  // wishbone classic master: hold until ack, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rdv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~wdat;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rdv, {24'h0, e});
  endtask : rd
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle
  task automatic frame_chk(input cbm_ident_type t, input logic [1:0] e,
    input cbm_ident_type f = FS);
    cbm_can_model_i.send(f, t);
    #1;
    chk({31'h0, acc_v}, 32'h1);
    chk({30'h0, accept}, {30'h0, e});
  endtask : frame_chk

  // ==========================================================================
  // main sequence
  initial begin
    {cyc, stb, we, resetn} = '0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_CTRL, 8'h04);
    rd(ADDR_DIR, 8'h00);
    // legacy mode: direction and type enable must stay absent
    wb(1'b1, ADDR_DIR, 8'hfc);
    rd(ADDR_DIR, 8'h00);
    wb(1'b1, 8'h44, 8'h08);
    rd(8'h44, 8'h00);
    settle();
    chk({26'h0, is_tx}, 32'h0);
    wb(1'b1, ADDR_CTRL, 8'h05);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, ROW_ADR[i], ROW_WR[i]);
      rd(ROW_ADR[i], ROW_RD[i]);
    end
    settle();
    chk({26'h0, is_tx}, 32'h3f);
    wb(1'b1, ADDR_DIR, 8'h04);
    wb(1'b1, 8'h20, 8'h48);
    cbm_can_model_i.req(3'h0);
    #1 chk({25'h0, desc}, 32'h70);
    wb(1'b1, 8'h20, 8'h09);
    cbm_can_model_i.req(3'h0);
    #1 chk({25'h0, desc}, 32'h51);
    cbm_can_model_i.req(3'h1);
    #1 chk({25'h0, desc}, 32'h00);
    // mask 0 standard bits all ones with type check, mask 1 open apart from extended-low 3c
    wb(1'b1, 8'h40, 8'hff);
    frame_chk(FE, 2'b10);
    frame_chk(FS, 2'b11);
    frame_chk(FD, 2'b10);
    wb(1'b1, 8'h44, 8'he3);
    frame_chk(FE, 2'b11);
    frame_chk(FE, 2'b11, FE);
    frame_chk(FE, 2'b10, FX);
    frame_chk(FS, 2'b11, FY);
    // outside configuration the masks must not move
    wb(1'b1, ADDR_CTRL, 8'h01);
    wb(1'b1, 8'h40, 8'h00);
    rd(8'h40, 8'hff);
    frame_chk(FD, 2'b10);
    // mid-run reset, then mode 2 and the legacy refusals once more
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    settle();
    chk({26'h0, is_tx}, 32'h0);
    rd(ADDR_CTRL, 8'h04);
    wb(1'b1, 8'h20, 8'h4f);
    rd(8'h20, 8'h00);
    wb(1'b1, ADDR_CTRL, 8'h06);
    rd(8'h20, 8'h00);
    rd(ADDR_DIR, 8'h00);
    rd(8'h44, 8'h00);
    wb(1'b1, 8'h44, 8'h08);
    rd(8'h44, 8'h08);
    wb(1'b1, ADDR_CTRL, 8'h04);
    rd(8'h44, 8'h00);
    frame_chk(FE, 2'b11);
    complete_run();
  end
endmodule : tb_cbm_top
`default_nettype wire
